// [hdl/mmap_pkg.sv]
// Package with constants and types for the memory address mapper
package mmap_pkg;

  // ----------------------------------------
  // Program space
  // ----------------------------------------
  localparam int MMAP_PC_W = 13;
  localparam int MMAP_PWORD_W = 14;
  localparam logic [12:0] MMAP_RESET_VEC = 13'h0000;
  localparam logic [12:0] MMAP_INT_VEC = 13'h0004;
  localparam logic [12:0] MMAP_MASK_8K = 13'h1fff;
  localparam logic [12:0] MMAP_MASK_4K = 13'h0fff;

  // ----------------------------------------
  // Data space
  // ----------------------------------------
  localparam int MMAP_OFS_W = 7;
  localparam int MMAP_DADDR_W = 9;
  localparam int MMAP_BSEL_HI_POS = 6;
  localparam int MMAP_BSEL_LO_POS = 5;
  localparam logic [6:0] MMAP_OFS_MAX = 7'h7f;
  localparam logic [6:0] MMAP_SFR_END = 7'h1f;
  localparam logic [6:0] MMAP_GPR_START = 7'h20;
  localparam logic [6:0] MMAP_INDIRECT_OFS = 7'h00;
  localparam logic [6:0] MMAP_SFR_EXT_END = 7'h0f;
  localparam logic [6:0] MMAP_SHARED_LO = 7'h70;
  localparam logic [7:0] MMAP_STATUS_RST = 8'h18;

  // Common-area offsets answering in every bank
  localparam logic [6:0] MMAP_OFS_PCL = 7'h02;
  localparam logic [6:0] MMAP_OFS_STATUS = 7'h03;
  localparam logic [6:0] MMAP_OFS_PTR = 7'h04;
  localparam logic [6:0] MMAP_OFS_PCLATH = 7'h0a;
  localparam logic [6:0] MMAP_OFS_INTCON = 7'h0b;

  typedef enum logic [1:0] {
    MMAP_REG_SFR = 2'h1,
    MMAP_REG_GPR = 2'h2
  } mmap_region_t;

  typedef enum logic [2:0] {
    MMAP_ST_RESET = 3'h1,
    MMAP_ST_RUN = 3'h2,
    MMAP_ST_VECTOR = 3'h4
  } mmap_state_t;

endpackage

// [hdl/mmap_dec_if.sv]
// Interface carrying a data address from the mapper to its decoder
`timescale 1ns/1ps
`default_nettype none
interface mmap_dec_if;
  import mmap_pkg::*;
  logic [8:0] daddr;
  mmap_region_t region;
  logic [8:0] phys;
  modport mapper (output daddr, input region, input phys);
  modport decoder (input daddr, output region, output phys);
endinterface
`default_nettype wire

// [hdl/mmap_region_dec.sv]
// Region decoder: splits a banked data address into SFR or RAM
`timescale 1ns/1ps
`default_nettype none
module mmap_region_dec
  import mmap_pkg::*;
(
  mmap_dec_if.decoder dec
);

  logic [1:0] bank;
  logic [6:0] ofs;

  always_comb begin
    bank = dec.daddr[8:7];
    ofs = dec.daddr[6:0];
    // Every bank keeps its SFR block at the bottom
    if (ofs <= MMAP_SFR_END) begin
      dec.region = MMAP_REG_SFR;
    end else begin
      dec.region = MMAP_REG_GPR;
    end
    dec.phys = dec.daddr;
    // High-use registers fold onto their bank 0 copy
    if (ofs == MMAP_INDIRECT_OFS || ofs == MMAP_OFS_PCL ||
        ofs == MMAP_OFS_STATUS || ofs == MMAP_OFS_PTR ||
        ofs == MMAP_OFS_PCLATH || ofs == MMAP_OFS_INTCON) begin
      dec.phys = {2'h0, ofs};
    end else if (ofs >= MMAP_SHARED_LO) begin
      // Top of each bank shares one RAM block
      dec.phys = {2'h0, ofs};
    end else if (bank[1] && !bank[0] && ofs <= MMAP_SFR_EXT_END &&
                 ofs[3:0] == 4'h1) begin
      dec.phys = {2'h0, ofs};
    end else if (bank[1] && bank[0] && ofs <= MMAP_SFR_EXT_END &&
                 ofs[3:0] == 4'h1) begin
      dec.phys = {2'h1, ofs};
    end
  end

endmodule
`default_nettype wire

// [hdl/mmap_core_map.sv]
// Program counter and banked data address mapper
`timescale 1ns/1ps
`default_nettype none
module mmap_core_map
  import mmap_pkg::*;
#(
  parameter bit HALF_PROG = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic srst,
  // Fetch side
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_val,
  input wire logic int_take,
  output logic [12:0] fetch_addr,
  output logic fetch_valid,
  // Data side
  input wire logic data_req,
  input wire logic data_we,
  input wire logic [6:0] data_ofs,
  input wire logic status_we,
  input wire logic [7:0] status_wdata,
  input wire logic ptr_we,
  input wire logic [7:0] ptr_wdata,
  output logic [8:0] data_addr,
  output logic data_is_sfr,
  output logic data_is_gpr,
  output logic data_indirect,
  output logic data_strobe,
  output logic data_wr,
  output logic [1:0] bank_sel,
  output logic [7:0] status_q,
  output logic [7:0] indirect_pointer
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mmap_state_t st;
    logic [12:0] pc;
    logic [12:0] fetch_addr;
    logic fetch_valid;
    logic [7:0] status;
    logic [7:0] ptr;
    logic [8:0] data_addr;
    logic data_is_sfr;
    logic data_is_gpr;
    logic data_indirect;
    logic data_strobe;
    logic data_wr;
  } mmap_regs_t;

  mmap_regs_t state_reg;
  mmap_regs_t state_next;

  mmap_dec_if dec_bus ();

  mmap_region_dec u_dec (
    .dec (dec_bus.decoder)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] wrap_pc(input logic [12:0] a);
    // Upper address bit is simply not wired on the small part
    if (HALF_PROG) begin
      return a & MMAP_MASK_4K;
    end
    return a & MMAP_MASK_8K;
  endfunction

  function automatic logic [1:0] bank_of(input logic [7:0] st);
    return {st[MMAP_BSEL_HI_POS], st[MMAP_BSEL_LO_POS]};
  endfunction

  logic [1:0] bank_now;
  logic [6:0] ofs_now;
  logic indirect_now;

  // ----------------------------------------
  // Data address forming
  // ----------------------------------------
  always_comb begin
    bank_now = bank_of(state_reg.status);
    ofs_now = data_ofs & MMAP_OFS_MAX;
    indirect_now = (ofs_now == MMAP_INDIRECT_OFS);
    if (indirect_now) begin
      // Pointer supplies offset, bank bit 8 from status bit 7
      dec_bus.daddr = {state_reg.status[7], state_reg.ptr};
    end else begin
      dec_bus.daddr = {bank_now, ofs_now};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.data_strobe = 1'b0;
    state_next.data_wr = 1'b0;
    unique case (state_reg.st)
      MMAP_ST_RESET: begin
        state_next.pc = MMAP_RESET_VEC;
        state_next.fetch_addr = MMAP_RESET_VEC;
        state_next.fetch_valid = 1'b1;
        state_next.st = MMAP_ST_RUN;
      end
      MMAP_ST_RUN: begin
        if (int_take) begin
          state_next.pc = MMAP_INT_VEC;
          state_next.fetch_addr = MMAP_INT_VEC;
          state_next.st = MMAP_ST_VECTOR;
        end else if (pc_load) begin
          state_next.pc = wrap_pc(pc_load_val);
          state_next.fetch_addr = wrap_pc(pc_load_val);
        end else if (pc_advance) begin
          state_next.pc = wrap_pc(13'(state_reg.pc + 13'h0001));
          state_next.fetch_addr = wrap_pc(13'(state_reg.pc + 13'h0001));
        end
      end
      MMAP_ST_VECTOR: begin
        // One cycle hold on the vector before normal stepping
        state_next.st = MMAP_ST_RUN;
      end
      default: begin
        state_next.st = MMAP_ST_RESET;
      end
    endcase

    // Data path runs in parallel with fetch each cycle
    if (data_req) begin
      state_next.data_addr = dec_bus.phys;
      state_next.data_is_sfr = (dec_bus.region == MMAP_REG_SFR);
      state_next.data_is_gpr = (dec_bus.region == MMAP_REG_GPR);
      state_next.data_indirect = indirect_now;
      state_next.data_strobe = 1'b1;
      state_next.data_wr = data_we;
    end
    if (status_we) begin
      state_next.status = status_wdata;
    end
    if (ptr_we) begin
      state_next.ptr = ptr_wdata;
    end

    if (srst) begin
      state_next = '0;
      state_next.st = MMAP_ST_RESET;
      state_next.pc = MMAP_RESET_VEC;
      state_next.fetch_addr = MMAP_RESET_VEC;
      state_next.status = MMAP_STATUS_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fetch_addr = state_reg.fetch_addr;
  assign fetch_valid = state_reg.fetch_valid;
  assign data_addr = state_reg.data_addr;
  assign data_is_sfr = state_reg.data_is_sfr;
  assign data_is_gpr = state_reg.data_is_gpr;
  assign data_indirect = state_reg.data_indirect;
  assign data_strobe = state_reg.data_strobe;
  assign data_wr = state_reg.data_wr;
  assign bank_sel = bank_of(state_reg.status);
  assign status_q = state_reg.status;
  assign indirect_pointer = state_reg.ptr;

endmodule
`default_nettype wire

// [test/mmap_core_mdl.sv]
// Core-side model that tallies data accesses
`timescale 1ns/1ps
`default_nettype none
module mmap_core_mdl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic data_strobe,
  output var logic [7:0] n_acc
);
  // One data access per strobe, independent of fetch
  always_ff @(posedge clk_sys) begin
    if (srst) n_acc <= 8'h00;
    else if (data_strobe) n_acc <= n_acc + 8'h01;
  end
endmodule
`default_nettype wire

// [test/mmap_props.sv]
// Checker with the address mapper's port properties
`timescale 1ns/1ps
`default_nettype none
module mmap_props
  import mmap_pkg::*;
#(
  parameter bit HALF_PROG = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_val,
  input wire logic int_take,
  input wire logic [12:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic data_req,
  input wire logic [6:0] data_ofs,
  input wire logic status_we,
  input wire logic [8:0] data_addr,
  input wire logic data_is_sfr,
  input wire logic data_is_gpr,
  input wire logic data_indirect,
  input wire logic data_strobe,
  input wire logic [1:0] bank_sel
);
  localparam logic [12:0] MSK = HALF_PROG ? MMAP_MASK_4K : MMAP_MASK_8K;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_rst; $past(srst) |-> fetch_addr == MMAP_RESET_VEC; endproperty
  a_rst: assert property (p_rst) else $error("fetch not at zero");
  // The reset cycle ignores fetch commands, fetch_valid is low there
  property p_vec;
    fetch_valid && int_take |=> fetch_addr == MMAP_INT_VEC;
  endproperty
  a_vec: assert property (p_vec) else $error("no vector");
  property p_adv;
    fetch_valid && pc_advance && !int_take && !pc_load && !$past(int_take)
      |=> fetch_addr == (($past(fetch_addr) + 13'h1) & MSK);
  endproperty
  a_adv: assert property (p_adv) else $error("bad step");
  property p_load;
    fetch_valid && pc_load && !int_take && !$past(int_take)
      |=> fetch_addr == ($past(pc_load_val) & MSK);
  endproperty
  a_load: assert property (p_load) else $error("bad load");
  property p_dir;
    data_req && !status_we && data_ofs inside {[7'h20:7'h6f]}
      |=> data_addr == {$past(bank_sel), $past(data_ofs)} && data_is_gpr;
  endproperty
  a_dir: assert property (p_dir) else $error("bad direct");
  property p_reg;
    data_req && data_ofs != MMAP_INDIRECT_OFS |=> data_is_gpr != data_is_sfr
      && data_is_sfr == ($past(data_ofs) <= MMAP_SFR_END);
  endproperty
  a_reg: assert property (p_reg) else $error("bad region");
  property p_ind; data_req && data_ofs == 7'h00 |=> data_indirect; endproperty
  a_ind: assert property (p_ind) else $error("not indirect");
  property p_mir;
    data_req && data_ofs == MMAP_OFS_STATUS |=> data_addr == 9'h003;
  endproperty
  a_mir: assert property (p_mir) else $error("no mirror");
  property p_stb; !$past(srst) |-> data_strobe == $past(data_req); endproperty
  a_stb: assert property (p_stb) else $error("bad strobe");
  c_vec: cover property (int_take ##1 pc_advance);
  c_ind: cover property (data_req && data_ofs == 7'h00);
  c_wrap: cover property (fetch_addr == MSK ##1 fetch_addr == 13'h0);
endmodule
bind mmap_core_map mmap_props #(.HALF_PROG(HALF_PROG)) mmap_props_inst (.*);
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the address mapper
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mmap_pkg::*;
  logic clk_sys = 0, srst = 1, pc_advance = 0, pc_load = 0, int_take = 0;
  logic data_req = 0, data_we = 0, status_we = 0, ptr_we = 0;
  logic [12:0] pc_load_val = 0, fetch_addr;
  logic [6:0] data_ofs = 0;
  logic [7:0] status_wdata = 0, ptr_wdata = 0, status_q, indirect_pointer;
  logic [7:0] n_acc;
  logic [8:0] data_addr;
  logic [1:0] bank_sel;
  logic fetch_valid, data_is_sfr, data_is_gpr, data_indirect;
  logic data_strobe, data_wr;
  int err_count = 0, n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  mmap_core_map #(.HALF_PROG(1'b1)) mmap_core_map_inst (.*);
  mmap_core_mdl mmap_core_mdl_inst (.*);
  task tick; @(posedge clk_sys); @(negedge clk_sys); endtask
  task chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Status is written a cycle ahead so the bank is settled
  task dacc(input logic [7:0] st, input logic [6:0] ofs, input logic [8:0] e);
    status_we = 1; status_wdata = st; tick; status_we = 0;
    data_req = 1; data_we = ofs[0]; data_ofs = ofs; tick; data_req = 0;
    chk(13'(data_addr), 13'(e));
    chk(13'(data_wr), 13'(data_we));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_pc;
    chk(fetch_addr, MMAP_RESET_VEC);
    chk(13'(status_q), 13'h0018);
    // First edge after release is the reset cycle, step ignored there
    pc_advance = 1; tick; tick; tick;
    chk(fetch_addr, 13'h0002);
    int_take = 1; tick; int_take = 0;
    chk(fetch_addr, MMAP_INT_VEC);
    tick; chk(fetch_addr, MMAP_INT_VEC);
    tick; pc_advance = 0; chk(fetch_addr, 13'h0005);
    $display("t_pc done");
  endtask
  task t_wrap;
    pc_load = 1; pc_load_val = 13'h1ffe; tick; pc_load = 0;
    chk(fetch_addr, 13'h0ffe);
    pc_advance = 1; tick; tick; pc_advance = 0;
    chk(fetch_addr, 13'h0000);
    $display("t_wrap done");
  endtask
  task t_bank;
    for (int b = 0; b < 4; b++) begin
      dacc(8'(b << 5), 7'h25, 9'(b * 128 + 'h25));
      chk(13'(data_is_gpr), 13'h0001);
      dacc(8'(b << 5), 7'h1e, 9'(b * 128 + 'h1e));
      chk(13'(data_is_sfr), 13'h0001);
    end
    dacc(8'h60, 7'h7f, 9'h07f);
    dacc(8'h40, MMAP_OFS_STATUS, 9'h003);
    $display("t_bank done");
  endtask
  task t_ind;
    ptr_we = 1; ptr_wdata = 8'h45; tick; ptr_we = 0;
    chk(13'(indirect_pointer), 13'h0045);
    dacc(8'h80, MMAP_INDIRECT_OFS, 9'h145);
    chk(13'(data_indirect), 13'h0001);
    $display("t_ind done");
  endtask
  // Fetch and data share the edge, neither may stall the other
  task t_par;
    pc_advance = 1; data_req = 1; data_ofs = 7'h30; tick;
    pc_advance = 0; data_req = 0;
    chk(fetch_addr, 13'h0001);
    chk(13'(data_strobe), 13'h0001);
    tick; chk(13'(data_strobe), 13'h0000);
    chk(13'(n_acc), 13'h000c);
    $display("t_par done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 0;
    t_pc; t_wrap; t_bank; t_ind; t_par;
    stop_test;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
